// File: pie_bank.sv
// What this block does
// - no peripheral request without peripheral-level enable
// - flags set regardless of any enable
// - enable bit passes or blocks its request
// - first enable register bit layout
// - bit1 timer2 match, bit0 timer1 overflow
// - second enable register bit layout
// - third enable register bit layout
// - unimplemented bits read zero, ignore writes
// - first flag register mirrors enable order
// - serial flags read-only, others writable
// - all bits zero after any reset
// - global enable passes or blocks the cpu request only
`include "pie_params.svh"

module pie_bank (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // first group event pulses
    input wire logic t1_gate_acq_set,
    input wire logic converter_done_set,
    input wire logic sync_port_set,
    input wire logic capture_unit1_set,
    input wire logic t2_match_set,
    input wire logic t1_overflow_set,
    // serial levels
    input wire logic serial_rx_pending,
    input wire logic serial_tx_pending,
    // second and third group flags
    input wire logic [7:0] flags_2_pending,
    input wire logic [7:0] flags_3_pending,
    // requests to the cpu
    output logic periph_request,
    output logic cpu_irq_request,
    // event interrupt
    output logic sys_irq
);

    // ----------------------------------------
    // shared helper
    // ----------------------------------------
    function automatic logic gated_any(
        input pie_pkg::byte_type flags,
        input pie_pkg::byte_type enables
    );
        gated_any = |(flags & enables);
    endfunction : gated_any

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    pie_pkg::index_type idx;
    logic sel_ctrl;
    logic sel_en1;
    logic sel_en2;
    logic sel_en3;
    logic sel_flg1;
    logic sel_stat;
    logic sel_mask;
    logic wr_ctrl;
    logic wr_en1;
    logic wr_en2;
    logic wr_en3;
    logic wr_flg1;
    logic wr_stat;
    logic wr_mask;

    assign idx = addr;
    assign sel_ctrl = (idx == `IDX_CORE_CTRL);
    assign sel_en1 = (idx == `IDX_ENABLE_1);
    assign sel_en2 = (idx == `IDX_ENABLE_2);
    assign sel_en3 = (idx == `IDX_ENABLE_3);
    assign sel_flg1 = (idx == `IDX_FLAGS_1);
    assign sel_stat = (idx == `IDX_EVT_STATUS);
    assign sel_mask = (idx == `IDX_EVT_MASK);
    assign wr_ctrl = wr & sel_ctrl;
    assign wr_en1 = wr & sel_en1;
    assign wr_en2 = wr & sel_en2;
    assign wr_en3 = wr & sel_en3;
    assign wr_flg1 = wr & sel_flg1;
    assign wr_stat = wr & sel_stat;
    assign wr_mask = wr & sel_mask;

    // ----------------------------------------
    // core control and enable registers
    // ----------------------------------------
    pie_pkg::byte_type core_irq_control;
    pie_pkg::byte_type peripheral_irq_enable_1;
    pie_pkg::byte_type peripheral_irq_enable_2;
    pie_pkg::byte_type peripheral_irq_enable_3;

    pie_enable_reg #(
        .WIDTH(8),
        .IMPL(`MASK_CORE_CTRL)
    ) u_core_ctrl (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .wr_en(wr_ctrl),
        .wdata(wdata),
        .q(core_irq_control)
    );

    pie_enable_reg #(
        .WIDTH(8),
        .IMPL(`MASK_ENABLE_1)
    ) u_enable_1 (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .wr_en(wr_en1),
        .wdata(wdata),
        .q(peripheral_irq_enable_1)
    );

    pie_enable_reg #(
        .WIDTH(8),
        .IMPL(`MASK_ENABLE_2)
    ) u_enable_2 (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .wr_en(wr_en2),
        .wdata(wdata),
        .q(peripheral_irq_enable_2)
    );

    pie_enable_reg #(
        .WIDTH(8),
        .IMPL(`MASK_ENABLE_3)
    ) u_enable_3 (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .wr_en(wr_en3),
        .wdata(wdata),
        .q(peripheral_irq_enable_3)
    );

    // ----------------------------------------
    // named enable fields
    // ----------------------------------------
    logic global_irq_enable;
    logic peripheral_level_enable;
    logic t1_gate_acq_enable;
    logic converter_done_enable;
    logic serial_rx_enable;
    logic serial_tx_enable;
    logic sync_port_enable;
    logic capture_unit1_enable;
    logic t2_match_enable;
    logic t1_overflow_enable;
    logic osc_fail_enable;
    logic comparator_b_enable;
    logic comparator_a_enable;
    logic eeprom_write_done_enable;
    logic bus_collision_enable;
    logic capture_unit2_enable;
    logic capture_unit4_enable;
    logic capture_unit3_enable;
    logic t6_match_enable;
    logic t4_match_enable;

    assign global_irq_enable = core_irq_control[`BIT_GLOBAL_EN];
    assign peripheral_level_enable = core_irq_control[`BIT_PERIPH_EN];
    assign t1_gate_acq_enable = peripheral_irq_enable_1[`BIT_T1_GATE];
    assign converter_done_enable = peripheral_irq_enable_1[`BIT_CONVERTER];
    assign serial_rx_enable = peripheral_irq_enable_1[`BIT_SERIAL_RX];
    assign serial_tx_enable = peripheral_irq_enable_1[`BIT_SERIAL_TX];
    assign sync_port_enable = peripheral_irq_enable_1[`BIT_SYNC_PORT];
    assign capture_unit1_enable = peripheral_irq_enable_1[`BIT_CAPTURE1];
    assign t2_match_enable = peripheral_irq_enable_1[`BIT_T2_MATCH];
    assign t1_overflow_enable = peripheral_irq_enable_1[`BIT_T1_OVF];
    assign osc_fail_enable = peripheral_irq_enable_2[`BIT_OSC_FAIL];
    assign comparator_b_enable = peripheral_irq_enable_2[`BIT_COMP_B];
    assign comparator_a_enable = peripheral_irq_enable_2[`BIT_COMP_A];
    assign eeprom_write_done_enable = peripheral_irq_enable_2[`BIT_EEPROM];
    assign bus_collision_enable = peripheral_irq_enable_2[`BIT_BUS_COLL];
    assign capture_unit2_enable = peripheral_irq_enable_2[`BIT_CAPTURE2];
    assign capture_unit4_enable = peripheral_irq_enable_3[`BIT_CAPTURE4];
    assign capture_unit3_enable = peripheral_irq_enable_3[`BIT_CAPTURE3];
    assign t6_match_enable = peripheral_irq_enable_3[`BIT_T6_MATCH];
    assign t4_match_enable = peripheral_irq_enable_3[`BIT_T4_MATCH];

    // ----------------------------------------
    // first flag register
    // ----------------------------------------
    pie_pkg::byte_type flag_set;
    pie_pkg::byte_type flag_level;
    pie_pkg::byte_type peripheral_irq_flags_1;

    assign flag_set = {t1_gate_acq_set, converter_done_set,
                       1'b0, 1'b0, sync_port_set, capture_unit1_set,
                       t2_match_set, t1_overflow_set};
    assign flag_level = {2'b00, serial_rx_pending, serial_tx_pending,
                         4'h0};

    pie_flag_bank #(
        .WIDTH(8),
        .RW_MASK(`MASK_FLAGS_1_RW)
    ) u_flags_1 (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .set(flag_set),
        .level(flag_level),
        .wr_en(wr_flg1),
        .wdata(wdata),
        .q(peripheral_irq_flags_1)
    );

    logic t1_gate_acq_flag;
    logic converter_done_flag;
    logic serial_rx_flag;
    logic serial_tx_flag;
    logic sync_port_flag;
    logic capture_unit1_flag;
    logic t2_match_flag;
    logic t1_overflow_flag;

    assign t1_gate_acq_flag = peripheral_irq_flags_1[`BIT_T1_GATE];
    assign converter_done_flag = peripheral_irq_flags_1[`BIT_CONVERTER];
    assign serial_rx_flag = peripheral_irq_flags_1[`BIT_SERIAL_RX];
    assign serial_tx_flag = peripheral_irq_flags_1[`BIT_SERIAL_TX];
    assign sync_port_flag = peripheral_irq_flags_1[`BIT_SYNC_PORT];
    assign capture_unit1_flag = peripheral_irq_flags_1[`BIT_CAPTURE1];
    assign t2_match_flag = peripheral_irq_flags_1[`BIT_T2_MATCH];
    assign t1_overflow_flag = peripheral_irq_flags_1[`BIT_T1_OVF];

    // ----------------------------------------
    // request combination
    // ----------------------------------------
    pie_pkg::byte_type flags_1_view;
    pie_pkg::byte_type en_1_view;
    pie_pkg::byte_type en_2_view;
    pie_pkg::byte_type en_3_view;
    logic any_group_1;
    logic any_group_2;
    logic any_group_3;
    logic any_request;
    logic periph_nxt;
    logic cpu_nxt;

    assign flags_1_view = {t1_gate_acq_flag, converter_done_flag,
                           serial_rx_flag, serial_tx_flag,
                           sync_port_flag, capture_unit1_flag,
                           t2_match_flag, t1_overflow_flag};
    assign en_1_view = {t1_gate_acq_enable, converter_done_enable,
                        serial_rx_enable, serial_tx_enable,
                        sync_port_enable, capture_unit1_enable,
                        t2_match_enable, t1_overflow_enable};
    assign en_2_view = {osc_fail_enable, comparator_b_enable, comparator_a_enable,
                        eeprom_write_done_enable, bus_collision_enable, 2'b00,
                        capture_unit2_enable};
    assign en_3_view = {2'b00, capture_unit4_enable, capture_unit3_enable,
                        t6_match_enable, 1'b0, t4_match_enable, 1'b0};
    // each enable gates its own flag
    assign any_group_1 = gated_any(flags_1_view, en_1_view);
    assign any_group_2 = gated_any(flags_2_pending, en_2_view);
    assign any_group_3 = gated_any(flags_3_pending, en_3_view);
    assign any_request = any_group_1 | any_group_2 | any_group_3;
    assign periph_nxt = any_request & peripheral_level_enable;
    assign cpu_nxt = periph_nxt & global_irq_enable;

    logic periph_r;
    logic cpu_r;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            periph_r <= 1'b0;
            cpu_r <= 1'b0;
        end else begin
            periph_r <= periph_nxt;
            cpu_r <= cpu_nxt;
        end
    end

    assign periph_request = periph_r;
    assign cpu_irq_request = cpu_r;

    // ----------------------------------------
    // event status and mask
    // ----------------------------------------
    pie_pkg::byte_type evt_pulse;
    pie_pkg::byte_type evt_status_r;
    pie_pkg::byte_type evt_status_nxt;
    pie_pkg::byte_type evt_mask_r;
    pie_pkg::byte_type evt_mask_nxt;
    pie_pkg::byte_type evt_clear;
    logic sys_irq_r;
    logic sys_irq_nxt;

    // rising edges of the two requests
    assign evt_pulse = {6'h00, cpu_nxt & ~cpu_r, periph_nxt & ~periph_r};
    assign evt_clear = wr_stat ? wdata : 8'h00;
    // a new event wins over a clear
    assign evt_status_nxt = `MASK_EVT &
                            (evt_pulse | (evt_status_r & ~evt_clear));
    assign evt_mask_nxt = wr_mask ? (wdata & `MASK_EVT) : evt_mask_r;
    assign sys_irq_nxt = |(evt_status_nxt & evt_mask_nxt);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            evt_status_r <= `RESET_BYTE;
            evt_mask_r <= `RESET_BYTE;
            sys_irq_r <= 1'b0;
        end else begin
            evt_status_r <= evt_status_nxt;
            evt_mask_r <= evt_mask_nxt;
            sys_irq_r <= sys_irq_nxt;
        end
    end

    assign sys_irq = sys_irq_r;

    // ----------------------------------------
    // read back
    // ----------------------------------------
    pie_pkg::byte_type rd_mux;
    pie_pkg::byte_type rdata_r;
    pie_pkg::byte_type rdata_nxt;

    // holes read zero, unmapped reads zero
    assign rd_mux = sel_ctrl ? core_irq_control :
                    sel_en1 ? peripheral_irq_enable_1 :
                    sel_en2 ? peripheral_irq_enable_2 :
                    sel_en3 ? peripheral_irq_enable_3 :
                    sel_flg1 ? peripheral_irq_flags_1 :
                    sel_stat ? evt_status_r :
                    sel_mask ? evt_mask_r :
                    8'h00;
    // data stand only in the cycle after the strobe
    assign rdata_nxt = rd ? rd_mux : 8'h00;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= `RESET_BYTE;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;

endmodule : pie_bank

// File: pie_params.svh
`ifndef PIE_PARAMS_SVH
`define PIE_PARAMS_SVH

// ----------------------------------------
// register indices on the port
// ----------------------------------------
`define IDX_CORE_CTRL 4'h0
`define IDX_ENABLE_1 4'h1
`define IDX_ENABLE_2 4'h2
`define IDX_ENABLE_3 4'h3
`define IDX_FLAGS_1 4'h4
`define IDX_EVT_STATUS 4'h5
`define IDX_EVT_MASK 4'h6

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_GLOBAL_EN 7
`define BIT_PERIPH_EN 6
`define BIT_T1_GATE 7
`define BIT_CONVERTER 6
`define BIT_SERIAL_RX 5
`define BIT_SERIAL_TX 4
`define BIT_SYNC_PORT 3
`define BIT_CAPTURE1 2
`define BIT_T2_MATCH 1
`define BIT_T1_OVF 0
`define BIT_OSC_FAIL 7
`define BIT_COMP_B 6
`define BIT_COMP_A 5
`define BIT_EEPROM 4
`define BIT_BUS_COLL 3
`define BIT_CAPTURE2 0
`define BIT_CAPTURE4 5
`define BIT_CAPTURE3 4
`define BIT_T6_MATCH 3
`define BIT_T4_MATCH 1
`define BIT_EVT_PERIPH 0
`define BIT_EVT_CPU 1

// ----------------------------------------
// implemented masks and reset values
// ----------------------------------------
`define MASK_CORE_CTRL 8'hC0
`define MASK_ENABLE_1 8'hFF
`define MASK_ENABLE_2 8'hF9
`define MASK_ENABLE_3 8'h3A
`define MASK_FLAGS_1_RW 8'hCF
`define MASK_EVT 8'h03
`define RESET_BYTE 8'h00

`endif

// File: pie_pkg.sv
package pie_pkg;

    typedef logic [7:0] byte_type;

    typedef logic [3:0] index_type;

endpackage : pie_pkg

// File: pie_enable_reg.sv
`include "pie_params.svh"

module pie_enable_reg #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] IMPL = '1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // write port
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wdata,
    // stored value
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    // unimplemented bits drop writes
    assign q_nxt = wr_en ? (wdata & IMPL) : q_r;
    assign q = q_r;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

endmodule : pie_enable_reg

// File: pie_flag_bank.sv
`include "pie_params.svh"

module pie_flag_bank #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RW_MASK = '1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // sources
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] level,
    // write port
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wdata,
    // stored flags
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] held;
    logic [WIDTH-1:0] q_nxt;

    // software may write only the writable bits
    assign held = wr_en ? wdata : q_r;
    // set wins over a clearing write
    assign q_nxt = (RW_MASK & (set | held)) | (~RW_MASK & level);
    assign q = q_r;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

endmodule : pie_flag_bank

// File: pie_bank_checker.sv
module pie_bank_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // sources
    input wire logic t1_overflow_set,
    input wire logic t2_match_set,
    input wire logic serial_rx_pending,
    input wire logic serial_tx_pending,
    // requests
    input wire logic periph_request,
    input wire logic cpu_irq_request,
    input wire logic sys_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    // ----------------------------------------
    // sequences and properties
    // ----------------------------------------
    sequence s_rd(logic [3:0] a);
        rd && addr == a;
    endsequence
    sequence s_ctrl_off(int b);
        wr && addr == 4'h0 && !wdata[b] ##1 !(wr && addr == 4'h0);
    endsequence
    property p_reset_quiet;
        $rose(arst_n) |-> rdata == 8'h00 && !periph_request && !cpu_irq_request && !sys_irq;
    endproperty
    property p_cpu_needs_periph;
        cpu_irq_request |-> periph_request;
    endproperty
    property p_en2_gap;
        s_rd(4'h2) |=> rdata[2:1] == 2'b00;
    endproperty
    property p_en3_gap;
        s_rd(4'h3) |=> (rdata & 8'hC5) == 8'h00;
    endproperty
    property p_rx_ro;
        s_rd(4'h4) |=> rdata[5] == $past(serial_rx_pending, 2);
    endproperty
    property p_tx_ro;
        s_rd(4'h4) |=> rdata[4] == $past(serial_tx_pending, 2);
    endproperty
    property p_t2_set;
        t2_match_set ##1 s_rd(4'h4) |=> rdata[1];
    endproperty
    property p_t1_set;
        t1_overflow_set ##1 s_rd(4'h4) |=> rdata[0];
    endproperty
    property p_periph_off;
        s_ctrl_off(6) |=> !periph_request;
    endproperty
    property p_global_off;
        s_ctrl_off(7) |=> !cpu_irq_request;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");
    a_cpu_needs_periph: assert property (p_cpu_needs_periph) else $error("cpu request alone");
    a_en2_gap: assert property (p_en2_gap) else $error("enable 2 gap bits set");
    a_en3_gap: assert property (p_en3_gap) else $error("enable 3 gap bits set");
    a_rx_ro: assert property (p_rx_ro) else $error("rx flag not following level");
    a_tx_ro: assert property (p_tx_ro) else $error("tx flag not following level");
    a_t2_set: assert property (p_t2_set) else $error("t2 flag not set");
    a_t1_set: assert property (p_t1_set) else $error("t1 overflow flag not set");
    a_periph_off: assert property (p_periph_off) else $error("request without level enable");
    a_global_off: assert property (p_global_off) else $error("cpu request without global");
endmodule : pie_bank_checker

bind pie_bank pie_bank_checker u_chk (.sys_clk(sys_clk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .t1_overflow_set(t1_overflow_set),
    .t2_match_set(t2_match_set), .serial_rx_pending(serial_rx_pending),
    .serial_tx_pending(serial_tx_pending), .periph_request(periph_request),
    .cpu_irq_request(cpu_irq_request), .sys_irq(sys_irq));

// File: pie_periph_model.sv
module pie_periph_model (
    // clock
    input wire logic sys_clk,
    // commands
    input wire logic [5:0] fire,
    input wire logic [1:0] ser_lvl,
    input wire logic [7:0] g2_lvl,
    input wire logic [7:0] g3_lvl,
    // source outputs
    output logic [5:0] pulse = 6'h00,
    output logic [1:0] ser = 2'h0,
    output logic [7:0] g2 = 8'h00,
    output logic [7:0] g3 = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(posedge sys_clk) begin
        pulse <= fire;
        ser <= ser_lvl;
        g2 <= g2_lvl;
        g3 <= g3_lvl;
    end
endmodule : pie_periph_model

// File: pie_bank_tb.sv
module pie_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;} row_type;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [5:0] fire = 6'h00;
    logic [1:0] ser_lvl = 2'h0;
    logic [7:0] g2_lvl = 8'h00;
    logic [7:0] g3_lvl = 8'h00;
    logic [7:0] rdata;
    logic periph_request;
    logic cpu_irq_request;
    logic sys_irq;
    logic [5:0] pulse;
    logic [1:0] ser;
    logic [7:0] g2;
    logic [7:0] g3;
    int fail_count = 0;
    int n_checks = 0;
    row_type rows [14] = '{{4'h0, 8'hFF, 8'hC0}, {4'h0, 8'h00, 8'h00}, {4'h1, 8'hFF, 8'hFF},
        {4'h2, 8'hFF, 8'hF9}, {4'h3, 8'hFF, 8'h3A}, {4'h6, 8'hFF, 8'h03},
        {4'h6, 8'h00, 8'h00}, {4'h7, 8'hFF, 8'h00}, {4'hF, 8'hFF, 8'h00},
        {4'h4, 8'hFF, 8'hCF}, {4'h4, 8'h00, 8'h00}, {4'h1, 8'h00, 8'h00},
        {4'h2, 8'h00, 8'h00}, {4'h3, 8'h00, 8'h00}};

    pie_periph_model u_model (.sys_clk(sys_clk), .fire(fire), .ser_lvl(ser_lvl),
        .g2_lvl(g2_lvl), .g3_lvl(g3_lvl), .pulse(pulse), .ser(ser), .g2(g2), .g3(g3));
    pie_bank u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .t1_gate_acq_set(pulse[5]),
        .converter_done_set(pulse[4]), .sync_port_set(pulse[3]),
        .capture_unit1_set(pulse[2]), .t2_match_set(pulse[1]),
        .t1_overflow_set(pulse[0]), .serial_rx_pending(ser[1]),
        .serial_tx_pending(ser[0]), .flags_2_pending(g2), .flags_3_pending(g3),
        .periph_request(periph_request), .cpu_irq_request(cpu_irq_request),
        .sys_irq(sys_irq));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : put
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk_byte
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk_bit
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk_byte(rdata, e);
    endtask : rd_chk
    task automatic pulse_src(input logic [5:0] m);
        @(posedge sys_clk);
        fire <= m;
        @(posedge sys_clk);
        fire <= 6'h00;
    endtask : pulse_src
    task automatic lv(input logic [1:0] s, input logic [7:0] a, input logic [7:0] b);
        @(posedge sys_clk);
        ser_lvl <= s;
        g2_lvl <= a;
        g3_lvl <= b;
    endtask : lv
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------
    // clock, watchdog, tests
    // ----------------------------------------
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #200000;
        fail_count++;
        close_out();
    end
    initial begin
        step(5);
        arst_n <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd_chk(i[3:0], 8'h00);
        foreach (rows[i]) begin
            put(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e);
        end
        pulse_src(6'h02);
        rd_chk(4'h4, 8'h02);
        step(2);
        chk_bit(periph_request, 1'b0);
        put(4'h1, 8'h02);
        put(4'h0, 8'h40);
        step(2);
        chk_bit(periph_request, 1'b1);
        chk_bit(cpu_irq_request, 1'b0);
        put(4'h0, 8'hC0);
        step(2);
        chk_bit(cpu_irq_request, 1'b1);
        put(4'h0, 8'h80);
        step(2);
        chk_bit(periph_request, 1'b0);
        chk_bit(cpu_irq_request, 1'b0);
        put(4'h0, 8'hC0);
        put(4'h1, 8'hFD);
        step(2);
        chk_bit(periph_request, 1'b0);
        rd_chk(4'h4, 8'h02);
        put(4'h4, 8'h00);
        rd_chk(4'h4, 8'h00);
        pulse_src(6'h3F);
        rd_chk(4'h4, 8'hCF);
        put(4'h4, 8'h00);
        lv(2'b11, 8'hFF, 8'hFF);
        step(2);
        rd_chk(4'h4, 8'h30);
        put(4'h4, 8'h00);
        rd_chk(4'h4, 8'h30);
        put(4'h1, 8'h00);
        put(4'h2, 8'h06);
        step(2);
        chk_bit(periph_request, 1'b0);
        put(4'h2, 8'h01);
        step(2);
        chk_bit(periph_request, 1'b1);
        put(4'h2, 8'h00);
        put(4'h3, 8'h20);
        step(2);
        chk_bit(periph_request, 1'b1);
        put(4'h3, 8'h00);
        lv(2'b00, 8'h00, 8'h00);
        step(2);
        rd_chk(4'h4, 8'h00);
        put(4'h5, 8'h03);
        put(4'h6, 8'h01);
        rd_chk(4'h5, 8'h00);
        put(4'h1, 8'h01);
        pulse_src(6'h01);
        step(3);
        chk_bit(sys_irq, 1'b1);
        rd_chk(4'h5, 8'h03);
        put(4'h5, 8'h01);
        step(2);
        chk_bit(sys_irq, 1'b0);
        rd_chk(4'h5, 8'h02);
        put(4'h6, 8'h02);
        step(1);
        chk_bit(sys_irq, 1'b1);
        put(4'h1, 8'hFF);
        pulse_src(6'h3F);
        step(2);
        chk_bit(cpu_irq_request, 1'b1);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        step(2);
        chk_bit(periph_request, 1'b0);
        chk_bit(sys_irq, 1'b0);
        chk_bit(cpu_irq_request, 1'b0);
        @(posedge sys_clk);
        arst_n <= 1'b1;
        rd_chk(4'h0, 8'h00);
        rd_chk(4'h1, 8'h00);
        rd_chk(4'h4, 8'h00);
        rd_chk(4'h5, 8'h00);
        rd_chk(4'h6, 8'h00);
        close_out();
    end
endmodule : pie_bank_tb
